// [scr_pkg.sv]
// Constants for the system configuration register bank
package scr_pkg;
	localparam logic [7:0] MODCFG_ADDR       = 8'h00;
	localparam logic [7:0] PAGE_ADDR         = 8'h01;
	localparam logic [7:0] COPY_ADDR         = 8'h02;
	localparam int         SHADOW_OFF_BIT    = 0;
	localparam int         HOST_SHARED_BIT   = 1;
	localparam int         WIDE_BUS_BIT      = 2;
	localparam int         ADDR15_BIT        = 3;
	localparam int         IO_EXP_BIT        = 4;
	localparam int         CLK_OUT_BIT       = 5;
	localparam int         TEST_HOOK_BIT     = 6;
	localparam logic [7:0] MODCFG_RESET      = 8'h00;
	localparam logic [7:0] MODCFG_WR_MASK    = 8'h3F;
	localparam logic [7:0] PAGE_RESET        = 8'h00;
	localparam logic [7:0] PAGE_WR_MASK      = 8'hFF;
	localparam logic [2:0] PAGE_FIELD_MASK   = 3'h7;
	localparam logic [18:0] BASE_SHADOW_ADDR = 19'h00000;
	localparam logic [18:0] BASE_MEM_ADDR    = 19'h10000;
	typedef enum logic [1:0] {
		SCR_ENV_INT_ROM,
		SCR_ENV_EXT_ROM,
		SCR_ENV_DEV
	} scr_env_t;
endpackage : scr_pkg

// [scr_pin_mux.sv]
// One multiplexed pin: port logic or alternate function
`timescale 1ns/100ps
module scr_pin_mux (
	// Select
	input  wire logic i_dedicated,
	input  wire logic i_alt_en,
	// Port side
	input  wire logic i_port_out,
	input  wire logic i_port_oe,
	// Alternate side
	input  wire logic i_alt_out,
	input  wire logic i_alt_oe,
	// Pad
	output logic      o_pad_out,
	output logic      o_pad_oe,
	output logic      o_alt_active
);
	wire use_alt = i_dedicated | i_alt_en;
	assign o_alt_active = use_alt;
	assign o_pad_out    = use_alt ? i_alt_out : i_port_out;
	assign o_pad_oe     = use_alt ? i_alt_oe : i_port_oe;
endmodule : scr_pin_mux

// [scr_config_regs.sv]
// System configuration registers with pin and address routing
//
// Local design decisions: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
module scr_config_regs (
	// Clock and reset
	input  wire logic            i_sys_clk,
	input  wire logic            i_srst,
	// Register port
	input  wire logic [7:0]      i_addr,
	input  wire logic [7:0]      i_wdata,
	input  wire logic            i_wr,
	input  wire logic            i_rd,
	output logic      [7:0]      o_rdata,
	// Environment and mode
	input  wire scr_pkg::scr_env_t i_env,
	input  wire logic            i_active_mode,
	input  wire logic            i_test_hook_pin,
	input  wire logic            i_shared_bios_strap_n,
	// Core and host address
	input  wire logic [15:0]     i_core_addr,
	input  wire logic            i_host_access,
	input  wire logic [18:0]     i_host_addr,
	output logic      [18:0]     o_mem_addr,
	output logic                 o_host_access_allowed,
	output logic                 o_external_enable,
	output logic                 o_base_shadow_active,
	output logic                 o_external_wide_bus,
	output logic                 o_port_f_byte_alt,
	// Port G pins, bits zero to two and four
	input  wire logic [3:0]      i_port_g_out,
	input  wire logic [3:0]      i_port_g_oe,
	input  wire logic            i_io_expansion_strobe,
	input  wire logic            i_addr15,
	input  wire logic            i_high_byte_write_strobe,
	output logic      [3:0]      o_pad_g_out,
	output logic      [3:0]      o_pad_g_oe,
	// Port B fixed pins
	output logic                 o_port_b_bit_five_oe,
	output logic                 o_port_b_bit_five_data,
	output logic                 o_port_b_bit_six_oe,
	output logic                 o_port_b_bit_six_alt,
	// Copy for development boards
	output logic      [7:0]      o_module_configuration_copy
);
	logic [7:0] module_configuration;
	logic [7:0] shared_memory_page;
	logic [7:0] next_module_configuration;
	logic [7:0] next_shared_memory_page;
	logic       test_hook_meta;
	logic       test_hook_sync;
	logic       strap_meta;
	logic       strap_sync;
	logic       strap_done;
	logic       active_meta;
	logic       active_sync;

	// Pins are asynchronous to the core clock
	always_ff @(posedge i_sys_clk) begin
		test_hook_meta <= i_test_hook_pin;
		test_hook_sync <= test_hook_meta;
		strap_meta     <= i_shared_bios_strap_n;
		strap_sync     <= strap_meta;
		active_meta    <= i_active_mode;
		active_sync    <= active_meta;
	end

	wire sel_cfg   = (i_addr == scr_pkg::MODCFG_ADDR);
	wire sel_page  = (i_addr == scr_pkg::PAGE_ADDR);
	wire sel_copy  = (i_addr == scr_pkg::COPY_ADDR);
	wire cfg_write = i_wr & sel_cfg & active_sync;
	wire page_write = i_wr & sel_page;
	// Strap is caught once, on the first clock after reset is released, from the second synchroniser stage
	wire strap_hit = ~strap_done & ~strap_sync;

	function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wd,
			input logic [7:0] mask);
		merge = (old & ~mask) | (wd & mask);
	endfunction : merge

	// Reserved and test bits ignore writes; test bit is read from the pin
	always_comb begin
		next_module_configuration = module_configuration;
		if (cfg_write) begin
			next_module_configuration = merge(module_configuration, i_wdata,
				scr_pkg::MODCFG_WR_MASK);
		end
		if (strap_hit) begin
			next_module_configuration[scr_pkg::ADDR15_BIT] = 1'b1;
		end
	end

	assign next_shared_memory_page = page_write ?
		merge(shared_memory_page, i_wdata, scr_pkg::PAGE_WR_MASK) : shared_memory_page;

	// Idle mode leaves the configuration untouched but for the strap's address-15 bit: no write path; the page register is written in any mode
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			module_configuration <= scr_pkg::MODCFG_RESET;
			shared_memory_page   <= scr_pkg::PAGE_RESET;
			strap_done           <= 1'b0;
		end else begin
			module_configuration <= next_module_configuration;
			shared_memory_page   <= next_shared_memory_page;
			strap_done           <= 1'b1;
		end
	end

	wire [7:0] cfg_view = {1'b0, test_hook_sync, module_configuration[5:0]};
	wire [7:0] read_mux = sel_cfg ? cfg_view :
		sel_page ? shared_memory_page :
		sel_copy ? cfg_view : 8'h00;

	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			o_rdata <= 8'h00;
		end else begin
			o_rdata <= i_rd ? read_mux : 8'h00;
		end
	end

	wire shadow_off = module_configuration[scr_pkg::SHADOW_OFF_BIT];
	wire host_en    = module_configuration[scr_pkg::HOST_SHARED_BIT];
	wire wide_bus   = module_configuration[scr_pkg::WIDE_BUS_BIT];
	wire host_ok    = shadow_off & host_en;
	wire dedicated  = (i_env != scr_pkg::SCR_ENV_INT_ROM);

	assign o_external_enable     = shadow_off;
	assign o_base_shadow_active  = ~shadow_off;
	assign o_host_access_allowed = host_ok;
	assign o_external_wide_bus   = wide_bus;
	assign o_port_f_byte_alt     = dedicated | wide_bus;
	assign o_module_configuration_copy = cfg_view;

	// Host address replaces the whole memory address only on an allowed host cycle
	wire [18:0] core_mem_addr = {shared_memory_page[2:0] & scr_pkg::PAGE_FIELD_MASK,
		i_core_addr};
	assign o_mem_addr = (i_host_access & host_ok) ? i_host_addr : core_mem_addr;

	wire [3:0] alt_en = {wide_bus,
		module_configuration[scr_pkg::CLK_OUT_BIT],
		module_configuration[scr_pkg::ADDR15_BIT],
		module_configuration[scr_pkg::IO_EXP_BIT]};
	wire [3:0] alt_out = {i_high_byte_write_strobe, i_sys_clk, i_addr15,
		i_io_expansion_strobe};

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_pin
			scr_pin_mux u_mux (
				.i_dedicated  (dedicated),
				.i_alt_en     (alt_en[gi]),
				.i_port_out   (i_port_g_out[gi]),
				.i_port_oe    (i_port_g_oe[gi]),
				.i_alt_out    (alt_out[gi]),
				.i_alt_oe     (1'b1),
				.o_pad_out    (o_pad_g_out[gi]),
				.o_pad_oe     (o_pad_g_oe[gi]),
				.o_alt_active ()
			);
		end
	endgenerate

	assign o_port_b_bit_five_oe   = 1'b1;
	assign o_port_b_bit_five_data = 1'b1;
	assign o_port_b_bit_six_oe    = 1'b1;
	assign o_port_b_bit_six_alt   = 1'b1;

	// Reset values, register storage and read-back
	a_reset_clears: assert property (
		@(posedge i_sys_clk)
		i_srst |=> module_configuration == scr_pkg::MODCFG_RESET)
		else $error("config not cleared by reset");

	a_page_reset: assert property (
		@(posedge i_sys_clk)
		i_srst |=> shared_memory_page == scr_pkg::PAGE_RESET)
		else $error("page not cleared by reset");

	a_rdata_idle: assert property (
		@(posedge i_sys_clk)
		(i_srst | ~i_rd) |=> o_rdata == 8'h00)
		else $error("read data not idle");

	a_idle_no_write: assert property (
		@(posedge i_sys_clk) disable iff (i_srst)
		(i_wr & sel_cfg & ~active_sync & strap_done) |=> $stable(module_configuration))
		else $error("config changed outside active mode");

	a_active_write: assert property (
		@(posedge i_sys_clk) disable iff (i_srst)
		(cfg_write & strap_done) |=> module_configuration[5:0] == $past(i_wdata[5:0]))
		else $error("config write lost");

	a_page_write: assert property (
		@(posedge i_sys_clk) disable iff (i_srst)
		page_write |=> shared_memory_page == $past(i_wdata))
		else $error("page write lost");

	a_test_readonly: assert property (
		@(posedge i_sys_clk) disable iff (i_srst)
		module_configuration[7:6] == 2'b00)
		else $error("read-only bits stored");

	a_hook_view: assert property (
		@(posedge i_sys_clk) disable iff (i_srst)
		o_module_configuration_copy[7:6] == {1'b0, test_hook_sync})
		else $error("test flag view wrong");

	a_cfg_read: assert property (
		@(posedge i_sys_clk) disable iff (i_srst)
		(i_rd & sel_cfg) |=> o_rdata == $past(cfg_view))
		else $error("config read wrong");

	a_read_timing: assert property (
		@(posedge i_sys_clk) disable iff (i_srst)
		(i_rd & sel_page) |=> o_rdata == $past(shared_memory_page))
		else $error("page read wrong");

	a_copy_read: assert property (
		@(posedge i_sys_clk) disable iff (i_srst)
		(i_rd & sel_copy) |=> o_rdata == $past(o_module_configuration_copy))
		else $error("copy read wrong");

	// Memory map and host gating
	a_shadow_map: assert property (
		@(posedge i_sys_clk) disable iff (i_srst)
		o_external_enable != o_base_shadow_active)
		else $error("shadow and external both on or off");

	a_host_gate: assert property (
		@(posedge i_sys_clk) disable iff (i_srst)
		o_host_access_allowed |-> (shadow_off && host_en))
		else $error("host allowed without both bits");

	a_host_blocked: assert property (
		@(posedge i_sys_clk) disable iff (i_srst)
		~host_en |-> ~o_host_access_allowed)
		else $error("host allowed with enable clear");

	a_blocked_host: assert property (
		@(posedge i_sys_clk) disable iff (i_srst)
		(i_host_access & ~host_ok) |-> o_mem_addr[15:0] == i_core_addr)
		else $error("blocked host reached memory");

	a_wide_port_f: assert property (
		@(posedge i_sys_clk) disable iff (i_srst)
		o_external_wide_bus |-> o_port_f_byte_alt)
		else $error("wide bus without port F");

	a_page_addr: assert property (
		@(posedge i_sys_clk) disable iff (i_srst)
		~i_host_access |-> o_mem_addr[18:16] == shared_memory_page[2:0])
		else $error("page bits not on address");

	a_host_addr: assert property (
		@(posedge i_sys_clk) disable iff (i_srst)
		(i_host_access & host_ok) |-> o_mem_addr == i_host_addr)
		else $error("host address not used");

	// Pin routing
	a_dedicated_pins: assert property (
		@(posedge i_sys_clk) disable iff (i_srst)
		dedicated |-> o_pad_g_oe == 4'hF)
		else $error("dedicated pins not driven");

	a_dedicated_route: assert property (
		@(posedge i_sys_clk) disable iff (i_srst)
		dedicated |-> o_pad_g_out[3] == i_high_byte_write_strobe &&
			o_pad_g_out[1:0] == {i_addr15, i_io_expansion_strobe})
		else $error("dedicated pins not on alternate");

	a_wide_pin: assert property (
		@(posedge i_sys_clk) disable iff (i_srst)
		o_external_wide_bus |-> o_pad_g_oe[3] &&
			o_pad_g_out[3] == i_high_byte_write_strobe)
		else $error("wide bus strobe pin wrong");

	a_addr15_pin: assert property (
		@(posedge i_sys_clk) disable iff (i_srst)
		~dedicated |-> o_pad_g_out[1] == (module_configuration[scr_pkg::ADDR15_BIT] ?
			i_addr15 : i_port_g_out[1]))
		else $error("address-15 pin wrong");

	a_strap_a15: assert property (
		@(posedge i_sys_clk) disable iff (i_srst)
		strap_hit |=> module_configuration[scr_pkg::ADDR15_BIT])
		else $error("strap did not set address-15 bit");

	a_io_strobe_pin: assert property (
		@(posedge i_sys_clk) disable iff (i_srst)
		~dedicated |-> o_pad_g_out[0] == (module_configuration[scr_pkg::IO_EXP_BIT] ?
			i_io_expansion_strobe : i_port_g_out[0]))
		else $error("expansion strobe pin wrong");

	a_clock_pin: assert property (
		@(posedge i_sys_clk) disable iff (i_srst)
		~dedicated |-> o_pad_g_oe[2] == (module_configuration[scr_pkg::CLK_OUT_BIT] |
			i_port_g_oe[2]))
		else $error("clock pin enable wrong");

	a_port_b_five: assert property (
		@(posedge i_sys_clk) disable iff (i_srst)
		o_port_b_bit_five_oe && o_port_b_bit_five_data)
		else $error("port B five not output high");

	a_port_b_six: assert property (
		@(posedge i_sys_clk) disable iff (i_srst)
		o_port_b_bit_six_oe && o_port_b_bit_six_alt)
		else $error("port B six not alternate output");

	c_cfg_write: cover property (
		@(posedge i_sys_clk) disable iff (i_srst)
		cfg_write);

	c_host_ok: cover property (
		@(posedge i_sys_clk) disable iff (i_srst)
		i_host_access & host_ok);

	c_idle_blocked: cover property (
		@(posedge i_sys_clk) disable iff (i_srst)
		i_wr & sel_cfg & ~active_sync);

	c_strap_set: cover property (
		@(posedge i_sys_clk) disable iff (i_srst)
		strap_hit);

	c_dedicated: cover property (
		@(posedge i_sys_clk) disable iff (i_srst)
		dedicated & cfg_write);
endmodule : scr_config_regs

// [scr_host_model.sv]
// Host side model that issues shared memory address requests
`timescale 1ns/100ps
module scr_host_model (
	// Clock
	input  wire logic        i_sys_clk,
	// Request from bench
	input  wire logic        i_go,
	input  wire logic [18:0] i_req_addr,
	// Host bus
	output logic             o_host_access,
	output logic      [18:0] o_host_addr
);
	initial begin
		o_host_access = 1'b0;
		o_host_addr   = 19'h00000;
	end
	// Idle bus shows inverted value so stale data never passes
	always @(posedge i_sys_clk) begin
		o_host_access <= i_go;
		o_host_addr   <= i_go ? i_req_addr : ~o_host_addr;
	end
endmodule : scr_host_model

// [tb_top.sv]
// Self-checking bench for the system configuration registers
`timescale 1ns/100ps
module tb_top;
	logic              clk, srst, wr, rd, act, hook, strap_n, go, hacc, a15, ios, hbw;
	logic        [7:0] addr, wdata, rdata, copy, cfg_m, page_m, d;
	logic       [15:0] core;
	logic       [18:0] haddr, hreq, maddr;
	logic        [3:0] pgo, pgoe, pado, padoe, sel, alt;
	logic              hallow, ext_en, shad, wide, pf_alt, b5oe, b5d, b6oe, b6alt;
	scr_pkg::scr_env_t env;
	integer            seed = 53, n_mismatch = 0, samples_checked = 0, i;
	scr_config_regs uut (.i_sys_clk(clk), .i_srst(srst), .i_addr(addr), .i_wdata(wdata),
		.i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_env(env), .i_active_mode(act),
		.i_test_hook_pin(hook), .i_shared_bios_strap_n(strap_n), .i_core_addr(core),
		.i_host_access(hacc), .i_host_addr(haddr), .o_mem_addr(maddr),
		.o_host_access_allowed(hallow), .o_external_enable(ext_en),
		.o_base_shadow_active(shad), .o_external_wide_bus(wide), .o_port_f_byte_alt(pf_alt),
		.i_port_g_out(pgo), .i_port_g_oe(pgoe), .i_io_expansion_strobe(ios), .i_addr15(a15),
		.i_high_byte_write_strobe(hbw), .o_pad_g_out(pado), .o_pad_g_oe(padoe),
		.o_port_b_bit_five_oe(b5oe), .o_port_b_bit_five_data(b5d),
		.o_port_b_bit_six_oe(b6oe), .o_port_b_bit_six_alt(b6alt),
		.o_module_configuration_copy(copy));
	scr_host_model host (.i_sys_clk(clk), .i_go(go), .i_req_addr(hreq),
		.o_host_access(hacc), .o_host_addr(haddr));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %0t signal got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		addr  <= a;
		wdata <= v;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask : wr_reg
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		samples_checked++;
		if (rdata !== exp) begin
			n_mismatch++;
			$display("ERROR %0t read %h got %h expected %h", $time, a, rdata, exp);
		end
	endtask : rd_chk
	task automatic final_report;
		$display("checked %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : final_report
	// Whole run is bounded
	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		final_report();
	end
	initial begin
		{srst, wr, rd, act, hook, go, a15, ios, hbw} = 9'h101;
		{addr, wdata, core, hreq, pgo, pgoe} = '0;
		strap_n = 1'b1;
		env = scr_pkg::SCR_ENV_INT_ROM;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		cfg_m = 8'h00;
		rd_chk(scr_pkg::MODCFG_ADDR, 8'h00);
		rd_chk(scr_pkg::PAGE_ADDR, 8'h00);
		rd_chk(8'h7E, 8'h00);
		chk({b5oe, b5d, b6oe, b6alt, shad, ext_en, hallow}, 7'h7C);
		$display("test reset done");
		// Configuration writes outside Active mode must be dropped
		act <= 1'b0;
		repeat (3) @(posedge clk);
		wr_reg(scr_pkg::MODCFG_ADDR, 8'h3C);
		act  <= 1'b1;
		hook <= 1'b1;
		rd_chk(scr_pkg::MODCFG_ADDR, 8'h00);
		repeat (3) @(posedge clk);
		for (i = 0; i < 12; i++) begin
			d = 8'($random(seed));
			d = {2'b00, d[5:2], 2'b00};
			{pgo, pgoe, ios, a15, hbw} <= 11'($random(seed));
			env <= scr_pkg::scr_env_t'(i % 3);
			wr_reg(scr_pkg::MODCFG_ADDR, d);
			cfg_m = d;
			sel = {cfg_m[2], cfg_m[5], cfg_m[3], cfg_m[4]} | {4{i % 3 != 0}};
			alt = {hbw, 1'b0, a15, ios};
			chk({padoe, pado & 4'hB},
				{sel | pgoe, ((sel & alt) | (~sel & pgo)) & 4'hB});
			chk(pado[2], sel[2] ? clk : pgo[2]);
			chk({ext_en, shad, wide, pf_alt}, {2'b01, cfg_m[2], cfg_m[2] | (i % 3 != 0)});
			rd_chk(scr_pkg::MODCFG_ADDR, {2'b01, cfg_m[5:0]});
			rd_chk(scr_pkg::COPY_ADDR, {2'b01, cfg_m[5:0]});
			chk(copy, {2'b01, cfg_m[5:0]});
			// Low clock phase, so the clock pin is seen in both levels
			#5;
			chk(pado[2], sel[2] ? clk : pgo[2]);
		end
		$display("test config fields done");
		// Shared memory bring-up order
		page_m = 8'($random(seed));
		core <= 16'($random(seed));
		hreq <= 19'($random(seed));
		wr_reg(scr_pkg::MODCFG_ADDR, cfg_m | 8'h01);
		cfg_m = cfg_m | 8'h01;
		wr_reg(scr_pkg::PAGE_ADDR, page_m);
		rd_chk(scr_pkg::PAGE_ADDR, page_m);
		go <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
		chk({hallow, ext_en, shad}, 3'h2);
		chk(maddr, {page_m[2:0], core});
		wr_reg(scr_pkg::MODCFG_ADDR, cfg_m | 8'h02);
		chk({hallow, maddr}, {1'b1, hreq});
		go <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		chk(maddr, {page_m[2:0], core});
		$display("test shared memory done");
		// Strap low through reset sets the address-15 enable
		strap_n <= 1'b0;
		srst <= 1'b1;
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		repeat (3) @(posedge clk);
		rd_chk(scr_pkg::MODCFG_ADDR, 8'h48);
		rd_chk(scr_pkg::PAGE_ADDR, 8'h00);
		$display("test strap done");
		final_report();
	end
endmodule : tb_top
